// *** include/gpr_pkg.sv ***
package gpr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL      = 16'hc006;
  localparam logic [15:0] IDX_LO_OUT    = 16'hc01e;
  localparam logic [15:0] IDX_LO_IN     = 16'hc020;
  localparam logic [15:0] IDX_LO_DIR    = 16'hc022;
  localparam logic [15:0] IDX_HI_OUT    = 16'hc024;
  localparam logic [15:0] IDX_HI_IN     = 16'hc026;
  localparam logic [15:0] IDX_HI_DIR    = 16'hc028;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'hc0f0;
  localparam logic [15:0] IDX_IRQ_CLR   = 16'hc0f2;
  localparam logic [15:0] IDX_IRQ_EN    = 16'hc0f4;

  localparam int unsigned ADDR_W = 18;
  localparam int unsigned IDX_LSB = 2;

  // Reset values
  localparam logic [15:0] RST_CTRL  = 16'h0000;
  localparam logic [15:0] RST_OUT   = 16'h0000;
  localparam logic [15:0] RST_DIR   = 16'h0000;
  localparam logic [1:0]  RST_IRQ   = 2'h0;

  // Control register fields
  localparam int unsigned CTL_WP       = 15;
  localparam int unsigned CTL_TXEN     = 14;
  localparam int unsigned CTL_SAS      = 11;
  localparam int unsigned CTL_MODE_LSB = 8;
  localparam int unsigned CTL_HSS      = 7;
  localparam int unsigned CTL_HSS_XD   = 6;
  localparam int unsigned CTL_SPI      = 5;
  localparam int unsigned CTL_SPI_XD   = 4;
  localparam int unsigned CTL_I1_POL   = 3;
  localparam int unsigned CTL_I1_EN    = 2;
  localparam int unsigned CTL_I0_POL   = 1;
  localparam int unsigned CTL_I0_EN    = 0;
  localparam logic [15:0] CTRL_WMASK   = 16'hcfff;
  localparam logic [15:0] CTRL_HI_MASK = 16'hff00;

  // Pin positions
  localparam int unsigned PIN_TXEN = 30;
  localparam int unsigned PIN_SAS  = 15;
  localparam int unsigned PIN_EXTERNAL_INTERRUPT_ONE = 25;
  localparam int unsigned PIN_EXTERNAL_INTERRUPT_ZERO = 24;
  localparam logic [31:0] LOWGRP_MASK = 32'h01f8ffff;
  // HIGH_SPEED_SERIAL lanes: txd, rxd, rts, cts; SPI lanes: sck, nss, mosi, miso
  localparam int unsigned HSS_PIN [4] = '{16, 17, 18, 26};
  localparam int unsigned SPI_PIN [4] = '{8, 9, 10, 11};
  localparam int unsigned SPI_NSS = 1;
  localparam int unsigned HSS_XD_LSB = 12;
  localparam int unsigned SPI_XD_LSB = 8;

  // Interrupt status bits
  localparam int unsigned ST_EXTERNAL_INTERRUPT_ZERO = 0;
  localparam int unsigned ST_EXTERNAL_INTERRUPT_ONE = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_GPIO  = 3'b000,
    MODE_DRIVE = 3'b100,
    MODE_HOST  = 3'b101,
    MODE_SCAN  = 3'b110
  } gpr_mode_t;

endpackage : gpr_pkg

// *** src/gpr_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Write-protect bit freezes control bits 15..8 until chip reset.
// - Routing bit 14 drives port 1A transmit-enable status onto pin 30.
// - Alternate slave-select moves SPI slave-select input from pin 9 to 15.
// - Mode field picks low group owner: IO, drive, host port, scan.
// - HIGH_SPEED_SERIAL enable routes high-speed serial to pins 26 and 18..16.
// - HIGH_SPEED_SERIAL memory-bus enable routes it to memory data 15..12, wins.
// - SPI enable routes serial-peripheral port onto pins 11..8.
// - SPI memory-bus enable routes to memory data 11..8, overrides SPI enable and alternate slave-select.
// - Interrupt one comes from pin 25, interrupt zero from pin 24.
// - Interrupt-one polarity bit: 1 rising edge, 0 falling edge.
// - Interrupt-zero polarity bit: 1 rising edge, 0 falling edge.
// - Interrupt delivered only when control enable and IO enable both set.
// - Output registers drive pins 15..0 and 31..16.
// - Output register reads back last written value.
// - Input registers return present pin levels.
// - Direction bit 1 makes output, 0 input; reset zero.
// - Control register at index 0xC006, read and write.
module gpr_top (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RSTN,
  // AXI4-Lite write address
  input  wire logic [gpr_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                      AWVALID,
  output logic                           AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]               WDATA,
  input  wire logic [3:0]                WSTRB,
  input  wire logic                      WVALID,
  output logic                           WREADY,
  // AXI4-Lite write response
  output logic [1:0]                     BRESP,
  output logic                           BVALID,
  input  wire logic                      BREADY,
  // AXI4-Lite read address
  input  wire logic [gpr_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                      ARVALID,
  output logic                           ARREADY,
  // AXI4-Lite read data
  output logic [31:0]                    RDATA,
  output logic [1:0]                     RRESP,
  output logic                           RVALID,
  input  wire logic                      RREADY,
  // Pins
  input  wire logic [31:0]               GPIO_I,
  output logic [31:0]                    GPIO_O,
  output logic [31:0]                    GPIO_OE,
  // External memory data bits 15..8
  input  wire logic [15:8]               XD_I,
  output logic [15:8]                    XD_O,
  output logic [15:8]                    XD_OE,
  output logic [15:8]                    XD_ROUTE,
  // Low group function
  output logic [2:0]                     MODE_SEL,
  output logic                           LOWGRP_OWN,
  input  wire logic [31:0]               ALT_O,
  input  wire logic [31:0]               ALT_OE,
  // High speed serial
  input  wire logic [3:0]                HSS_O,
  input  wire logic [3:0]                HSS_OE,
  output logic [3:0]                     HSS_I,
  // Serial peripheral
  input  wire logic [3:0]                SPI_O,
  input  wire logic [3:0]                SPI_OE,
  output logic [3:0]                     SPI_I,
  // Port 1A transmitter enable status
  input  wire logic                      USB_TXEN,
  // Interrupt
  output logic                           IRQ
);
  import gpr_pkg::*;

  logic [15:0] ctrl_ff, lo_out_ff, hi_out_ff, lo_dir_ff, hi_dir_ff;
  logic [1:0]  irq_stat_ff, irq_en_ff;
  logic [31:0] pin_s1_ff, pin_s2_ff, pin_prev_ff;
  logic [15:8] xd_s1_ff, xd_s2_ff;
  logic [31:0] nxt_pin_o, nxt_pin_oe, pin_o_ff, pin_oe_ff;
  logic [15:8] nxt_xd_o, nxt_xd_oe, nxt_xd_route;
  logic [15:8] xd_o_ff, xd_oe_ff, xd_route_ff;
  logic [3:0]  nxt_hss_i, nxt_spi_i, hss_i_ff, spi_i_ff;
  logic        irq_ff, bvalid_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  logic        wr_go, rd_go, wr_hit, rd_hit;
  logic [15:0] wr_idx, rd_idx, wmask, wval, rd_val;

  // Decoded routing
  logic        hss_gpio_on, hss_xd_on, spi_gpio_on, spi_xd_on;
  logic        sas_on, lowgrp_on, edge0, edge1;
  logic [31:0] hss_mask, spi_mask, fn_o, fn_oe;
  logic [31:0] fn_mask, gpio_out, gpio_dir;
  logic [1:0]  irq_set;

  // AXI4-Lite slave: one write and one read at a time
  assign wr_go   = AWVALID && WVALID && !bvalid_ff;
  assign rd_go   = ARVALID && !rvalid_ff;
  assign AWREADY = wr_go;
  assign WREADY  = wr_go;
  assign ARREADY = rd_go;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign RVALID  = rvalid_ff;
  assign RRESP   = rresp_ff;
  assign RDATA   = rdata_ff;

  assign wr_idx = AWADDR[ADDR_W-1:IDX_LSB];
  assign rd_idx = ARADDR[ADDR_W-1:IDX_LSB];
  assign wmask  = {{8{WSTRB[1]}}, {8{WSTRB[0]}}};
  assign wval   = WDATA[15:0];

  always_comb begin
    unique case (wr_idx)
      IDX_CTRL, IDX_LO_OUT, IDX_LO_DIR, IDX_HI_OUT, IDX_HI_DIR,
      IDX_LO_IN, IDX_HI_IN, IDX_IRQ_STAT, IDX_IRQ_CLR,
      IDX_IRQ_EN: wr_hit = 1'b1;
      default:    wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    unique case (rd_idx)
      IDX_CTRL:     rd_val = ctrl_ff;
      IDX_LO_OUT:   rd_val = lo_out_ff;
      IDX_HI_OUT:   rd_val = hi_out_ff;
      IDX_LO_IN:    rd_val = pin_s2_ff[15:0];
      IDX_HI_IN:    rd_val = pin_s2_ff[31:16];
      IDX_LO_DIR:   rd_val = lo_dir_ff;
      IDX_HI_DIR:   rd_val = hi_dir_ff;
      IDX_IRQ_STAT: rd_val = {14'h0000, irq_stat_ff};
      IDX_IRQ_CLR:  rd_val = 16'h0000;
      IDX_IRQ_EN:   rd_val = {14'h0000, irq_en_ff};
      default:      rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h00000000;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_ff  <= {16'h0000, rd_val};
    end else if (RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Control register; reserved bits hold zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_ff <= RST_CTRL;
    end else if (wr_go && wr_idx == IDX_CTRL) begin
      if (ctrl_ff[CTL_WP]) begin
        ctrl_ff <= (ctrl_ff & ~(wmask & CTRL_WMASK & ~CTRL_HI_MASK))
                 | (wval & wmask & CTRL_WMASK & ~CTRL_HI_MASK);
      end else begin
        ctrl_ff <= (ctrl_ff & ~(wmask & CTRL_WMASK))
                 | (wval & wmask & CTRL_WMASK);
      end
    end
  end

  // Output value registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lo_out_ff <= RST_OUT;
      hi_out_ff <= RST_OUT;
    end else if (wr_go) begin
      if (wr_idx == IDX_LO_OUT)
        lo_out_ff <= (lo_out_ff & ~wmask) | (wval & wmask);
      if (wr_idx == IDX_HI_OUT)
        hi_out_ff <= (hi_out_ff & ~wmask) | (wval & wmask);
    end
  end

  // Direction registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lo_dir_ff <= RST_DIR;
      hi_dir_ff <= RST_DIR;
    end else if (wr_go) begin
      if (wr_idx == IDX_LO_DIR)
        lo_dir_ff <= (lo_dir_ff & ~wmask) | (wval & wmask);
      if (wr_idx == IDX_HI_DIR)
        hi_dir_ff <= (hi_dir_ff & ~wmask) | (wval & wmask);
    end
  end

  // Pin and memory bus input synchronisers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1_ff   <= 32'h00000000;
      pin_s2_ff   <= 32'h00000000;
      pin_prev_ff <= 32'h00000000;
      xd_s1_ff    <= 8'h00;
      xd_s2_ff    <= 8'h00;
    end else begin
      pin_s1_ff   <= GPIO_I;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
      xd_s1_ff    <= XD_I;
      xd_s2_ff    <= xd_s1_ff;
    end
  end

  // Edge detection on the two interrupt pins
  assign edge0 = ctrl_ff[CTL_I0_POL]
               ? (pin_s2_ff[PIN_EXTERNAL_INTERRUPT_ZERO] && !pin_prev_ff[PIN_EXTERNAL_INTERRUPT_ZERO])
               : (!pin_s2_ff[PIN_EXTERNAL_INTERRUPT_ZERO] && pin_prev_ff[PIN_EXTERNAL_INTERRUPT_ZERO]);
  assign edge1 = ctrl_ff[CTL_I1_POL]
               ? (pin_s2_ff[PIN_EXTERNAL_INTERRUPT_ONE] && !pin_prev_ff[PIN_EXTERNAL_INTERRUPT_ONE])
               : (!pin_s2_ff[PIN_EXTERNAL_INTERRUPT_ONE] && pin_prev_ff[PIN_EXTERNAL_INTERRUPT_ONE]);
  assign irq_set = {edge1, edge0};

  // Sticky status; a new edge wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_ff <= RST_IRQ;
    end else if (wr_go && wr_idx == IDX_IRQ_CLR && WSTRB[0]) begin
      irq_stat_ff <= (irq_stat_ff & ~WDATA[1:0]) | irq_set;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_set;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_en_ff <= RST_IRQ;
    end else if (wr_go && wr_idx == IDX_IRQ_EN && WSTRB[0]) begin
      irq_en_ff <= WDATA[1:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (irq_stat_ff[ST_EXTERNAL_INTERRUPT_ZERO] && irq_en_ff[ST_EXTERNAL_INTERRUPT_ZERO]
                 && ctrl_ff[CTL_I0_EN])
             || (irq_stat_ff[ST_EXTERNAL_INTERRUPT_ONE] && irq_en_ff[ST_EXTERNAL_INTERRUPT_ONE]
                 && ctrl_ff[CTL_I1_EN]);
    end
  end
  assign IRQ = irq_ff;

  // Routing decode
  assign hss_xd_on   = ctrl_ff[CTL_HSS_XD];
  assign hss_gpio_on = ctrl_ff[CTL_HSS] && !ctrl_ff[CTL_HSS_XD];
  assign spi_xd_on   = ctrl_ff[CTL_SPI_XD];
  assign spi_gpio_on = ctrl_ff[CTL_SPI] && !ctrl_ff[CTL_SPI_XD];
  assign sas_on      = spi_gpio_on && ctrl_ff[CTL_SAS];

  always_comb begin
    unique case (ctrl_ff[CTL_MODE_LSB +: 3])
      MODE_DRIVE, MODE_HOST, MODE_SCAN: lowgrp_on = 1'b1;
      default:                          lowgrp_on = 1'b0;
    endcase
  end

  // Per-pin function ownership and drive
  always_comb begin
    hss_mask = 32'h00000000;
    spi_mask = 32'h00000000;
    fn_o     = 32'h00000000;
    fn_oe    = 32'h00000000;
    for (int k = 0; k < 4; k++) begin
      if (hss_gpio_on) begin
        hss_mask[HSS_PIN[k]] = 1'b1;
        fn_o[HSS_PIN[k]]     = HSS_O[k];
        fn_oe[HSS_PIN[k]]    = HSS_OE[k];
      end
    end
    for (int k = 0; k < 4; k++) begin
      if (spi_gpio_on && !(k == SPI_NSS && sas_on)) begin
        spi_mask[SPI_PIN[k]] = 1'b1;
        fn_o[SPI_PIN[k]]     = SPI_O[k];
        fn_oe[SPI_PIN[k]]    = SPI_OE[k];
      end
    end
    if (sas_on) begin
      spi_mask[PIN_SAS] = 1'b1;
      fn_o[PIN_SAS]     = SPI_O[SPI_NSS];
      fn_oe[PIN_SAS]    = SPI_OE[SPI_NSS];
    end
  end

  assign fn_mask  = hss_mask | spi_mask;
  assign gpio_out = {hi_out_ff, lo_out_ff};
  assign gpio_dir = {hi_dir_ff, lo_dir_ff};

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_pin
      always_comb begin
        if (gi == PIN_TXEN && ctrl_ff[CTL_TXEN]) begin
          nxt_pin_o[gi]  = USB_TXEN;
          nxt_pin_oe[gi] = 1'b1;
        end else if (fn_mask[gi]) begin
          nxt_pin_o[gi]  = fn_o[gi];
          nxt_pin_oe[gi] = fn_oe[gi];
        end else if (lowgrp_on && LOWGRP_MASK[gi]) begin
          nxt_pin_o[gi]  = ALT_O[gi];
          nxt_pin_oe[gi] = ALT_OE[gi];
        end else begin
          nxt_pin_o[gi]  = gpio_out[gi];
          nxt_pin_oe[gi] = gpio_dir[gi];
        end
      end
    end
  endgenerate

  // Memory data bus routing and function inputs
  always_comb begin
    nxt_xd_o     = 8'h00;
    nxt_xd_oe    = 8'h00;
    nxt_xd_route = 8'h00;
    nxt_hss_i    = 4'h0;
    nxt_spi_i    = 4'h0;
    for (int k = 0; k < 4; k++) begin
      if (hss_xd_on) begin
        nxt_xd_route[HSS_XD_LSB + k] = 1'b1;
        nxt_xd_o[HSS_XD_LSB + k]     = HSS_O[k];
        nxt_xd_oe[HSS_XD_LSB + k]    = HSS_OE[k];
        nxt_hss_i[k]                 = xd_s2_ff[HSS_XD_LSB + k];
      end else begin
        nxt_hss_i[k] = pin_s2_ff[HSS_PIN[k]];
      end
      if (spi_xd_on) begin
        nxt_xd_route[SPI_XD_LSB + k] = 1'b1;
        nxt_xd_o[SPI_XD_LSB + k]     = SPI_O[k];
        nxt_xd_oe[SPI_XD_LSB + k]    = SPI_OE[k];
        nxt_spi_i[k]                 = xd_s2_ff[SPI_XD_LSB + k];
      end else if (k == SPI_NSS && sas_on) begin
        nxt_spi_i[k] = pin_s2_ff[PIN_SAS];
      end else begin
        nxt_spi_i[k] = pin_s2_ff[SPI_PIN[k]];
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_o_ff    <= 32'h00000000;
      pin_oe_ff   <= 32'h00000000;
      xd_o_ff     <= 8'h00;
      xd_oe_ff    <= 8'h00;
      xd_route_ff <= 8'h00;
      hss_i_ff    <= 4'h0;
      spi_i_ff    <= 4'h0;
    end else begin
      pin_o_ff    <= nxt_pin_o;
      pin_oe_ff   <= nxt_pin_oe;
      xd_o_ff     <= nxt_xd_o;
      xd_oe_ff    <= nxt_xd_oe;
      xd_route_ff <= nxt_xd_route;
      hss_i_ff    <= nxt_hss_i;
      spi_i_ff    <= nxt_spi_i;
    end
  end

  assign GPIO_O     = pin_o_ff;
  assign GPIO_OE    = pin_oe_ff;
  assign XD_O       = xd_o_ff;
  assign XD_OE      = xd_oe_ff;
  assign XD_ROUTE   = xd_route_ff;
  assign HSS_I      = hss_i_ff;
  assign SPI_I      = spi_i_ff;
  assign MODE_SEL   = ctrl_ff[CTL_MODE_LSB +: 3];
  assign LOWGRP_OWN = lowgrp_on;

endmodule : gpr_top

`default_nettype wire

// *** sim/gpr_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpr_pins #(
  parameter int W = 32
) (
  // Clock
  input  wire logic         clk,
  // Device side
  input  wire logic [W-1:0] o,
  input  wire logic [W-1:0] oe,
  // Far side drive
  input  wire logic [W-1:0] ext_v,
  input  wire logic [W-1:0] ext_en,
  output logic [W-1:0]      pin
);
  logic [W-1:0] last_ff = '0;

  // Device drive wins; an undriven line shows the inverse of its last level
  always_comb pin = (oe & o) | (~oe & ext_en & ext_v)
                  | (~oe & ~ext_en & ~last_ff);

  always @(posedge clk) last_ff <= pin;
endmodule : gpr_pins
`default_nettype wire

// *** sim/gpr_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpr_chk (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RSTN,
  // Register bus
  input  wire logic [gpr_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                       AWVALID,
  input  wire logic                       AWREADY,
  input  wire logic [31:0]                WDATA,
  input  wire logic                       WVALID,
  input  wire logic                       WREADY,
  input  wire logic [1:0]                 BRESP,
  input  wire logic                       BVALID,
  input  wire logic                       BREADY,
  input  wire logic                       ARVALID,
  input  wire logic                       ARREADY,
  input  wire logic [31:0]                RDATA,
  input  wire logic                       RVALID,
  input  wire logic                       RREADY,
  // Pins and functions
  input  wire logic [31:0]                GPIO_O,
  input  wire logic [31:0]                GPIO_OE,
  input  wire logic [15:8]                XD_O,
  input  wire logic [15:8]                XD_OE,
  input  wire logic [2:0]                 MODE_SEL,
  input  wire logic                       LOWGRP_OWN,
  input  wire logic [31:0]                ALT_O,
  input  wire logic [3:0]                 HSS_O,
  input  wire logic [3:0]                 HSS_OE,
  input  wire logic [3:0]                 SPI_O,
  input  wire logic [3:0]                 SPI_OE,
  input  wire logic                       USB_TXEN,
  input  wire logic                       IRQ
);
  import gpr_pkg::*;
  logic [15:0] ctl_ff;

  // Shadow of the control register, upper byte frozen once locked
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) ctl_ff <= 16'h0000;
    else if (AWVALID && AWREADY && WVALID && WREADY &&
             AWADDR[17:2] == IDX_CTRL)
      ctl_ff <= ctl_ff[15] ? {ctl_ff[15:8], WDATA[7:0]}
                           : WDATA[15:0] & CTRL_WMASK;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY
    |=> BVALID) else $error("write response missing");
  a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_rd_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read response missing");
  a_rd_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_mode_field: assert property (MODE_SEL == ctl_ff[10:8])
    else $error("mode select wrong");
  a_lowgrp_own: assert property (LOWGRP_OWN ==
    (MODE_SEL inside {3'b100, 3'b101, 3'b110}))
    else $error("low group owner wrong");
  a_low_alt: assert property ($past(LOWGRP_OWN) |->
    GPIO_O[7:0] == $past(ALT_O[7:0]))
    else $error("low group not driven by function");
  a_tx_route: assert property ($past(ctl_ff[14]) |->
    GPIO_OE[30] && GPIO_O[30] == $past(USB_TXEN))
    else $error("tx enable not on pin 30");
  a_hss_pins: assert property ($past(ctl_ff[7]) && !$past(ctl_ff[6]) |->
    {GPIO_O[26], GPIO_O[18:16]} == $past(HSS_O) &&
    {GPIO_OE[26], GPIO_OE[18:16]} == $past(HSS_OE))
    else $error("fast serial not on pins");
  a_hss_xd: assert property ($past(ctl_ff[6]) |->
    XD_O[15:12] == $past(HSS_O) && XD_OE[15:12] == $past(HSS_OE))
    else $error("fast serial not on memory bus");
  a_spi_pins: assert property ($past(ctl_ff[5]) && !$past(ctl_ff[4]) &&
    !$past(ctl_ff[11])
    |-> GPIO_O[11:8] == $past(SPI_O) && GPIO_OE[11:8] == $past(SPI_OE))
    else $error("serial peripheral not on pins");
  a_spi_xd: assert property ($past(ctl_ff[4]) |->
    XD_O[11:8] == $past(SPI_O) && XD_OE[11:8] == $past(SPI_OE))
    else $error("serial peripheral not on memory bus");
  a_irq_gate: assert property ($rose(IRQ) |->
    $past(ctl_ff[0]) || $past(ctl_ff[2]))
    else $error("interrupt without enable");

  c_xd_route: cover property (ctl_ff[6] && ctl_ff[4]);
  c_lowgrp: cover property (LOWGRP_OWN);
  c_irq: cover property ($rose(IRQ));
  c_locked: cover property (ctl_ff[15]);
endmodule : gpr_chk

bind gpr_top gpr_chk u_chk (
  .CLK(CLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WDATA(WDATA), .WVALID(WVALID), .WREADY(WREADY),
  .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
  .GPIO_O(GPIO_O), .GPIO_OE(GPIO_OE), .XD_O(XD_O), .XD_OE(XD_OE),
  .MODE_SEL(MODE_SEL), .LOWGRP_OWN(LOWGRP_OWN), .ALT_O(ALT_O),
  .HSS_O(HSS_O), .HSS_OE(HSS_OE), .SPI_O(SPI_O), .SPI_OE(SPI_OE),
  .USB_TXEN(USB_TXEN), .IRQ(IRQ)
);
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gpr_pkg::*;
  logic        CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic [17:0] AWADDR = '0, ARADDR = '0;
  logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic        USB_TXEN = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [31:0] WDATA = '0, ALT_O = '0, ALT_OE = '0, ext_v = '0;
  logic [31:0] RDATA, GPIO_O, GPIO_OE, GPIO_I;
  logic [3:0]  HSS_O = '0, HSS_OE = '0, SPI_O = '0, SPI_OE = '0;
  logic [3:0]  HSS_I, SPI_I;
  logic [7:0]  xd_v = '0;
  logic [15:8] XD_I, XD_O, XD_OE, XD_ROUTE;
  logic [1:0]  BRESP, RRESP;
  logic [2:0]  MODE_SEL;
  logic        LOWGRP_OWN;
  int          n_errors = 0, n_tests = 0, cyc = 0;
  localparam logic [15:0] RI [8] = '{IDX_CTRL, IDX_LO_OUT, IDX_LO_IN,
    IDX_LO_DIR, IDX_HI_OUT, IDX_HI_IN, IDX_HI_DIR, IDX_IRQ_EN};

  gpr_top dut (.CLK(CLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .GPIO_I(GPIO_I),
    .GPIO_O(GPIO_O), .GPIO_OE(GPIO_OE), .XD_I(XD_I), .XD_O(XD_O),
    .XD_OE(XD_OE), .XD_ROUTE(XD_ROUTE), .MODE_SEL(MODE_SEL),
    .LOWGRP_OWN(LOWGRP_OWN), .ALT_O(ALT_O), .ALT_OE(ALT_OE), .HSS_O(HSS_O),
    .HSS_OE(HSS_OE), .HSS_I(HSS_I), .SPI_O(SPI_O), .SPI_OE(SPI_OE),
    .SPI_I(SPI_I), .USB_TXEN(USB_TXEN), .IRQ(IRQ));
  gpr_pins #(.W(32)) u_pins (.clk(CLK), .o(GPIO_O), .oe(GPIO_OE),
    .ext_v(ext_v), .ext_en(32'hffffffff), .pin(GPIO_I));
  gpr_pins #(.W(8)) u_xd (.clk(CLK), .o(XD_O), .oe(XD_OE), .ext_v(xd_v),
    .ext_en(8'hff), .pin(XD_I));

  initial forever #50 CLK = ~CLK;

  task give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] i, input logic [15:0] v,
                    input logic [1:0] e = RESP_OKAY);
    @(posedge CLK);
    AWADDR <= {i, 2'b00};
    WDATA <= {16'h0000, v};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever begin
      @(posedge CLK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
      if (BVALID === 1'b1) break;
    end
    BREADY <= 1'b0;
    chk(BRESP, e);
  endtask : wr

  task automatic rd(input logic [15:0] i, input logic [15:0] v,
                    input logic [1:0] e = RESP_OKAY);
    @(posedge CLK);
    ARADDR <= {i, 2'b00};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    forever begin
      @(posedge CLK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
      if (RVALID === 1'b1) break;
    end
    RREADY <= 1'b0;
    chk(RDATA, {16'h0000, v});
    chk(RRESP, e);
  endtask : rd

  initial begin
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    foreach (RI[k]) rd(RI[k], 16'h0000);
    rd(16'h0100, 16'h0000, RESP_SLVERR);
    $display("Reset values done");
    wr(IDX_LO_OUT, 16'ha5c3);
    wr(IDX_LO_DIR, 16'h00ff);
    wr(IDX_HI_OUT, 16'h1234);
    wr(IDX_HI_DIR, 16'hff00);
    wr(16'h0100, 16'hffff, RESP_SLVERR);
    ext_v <= 32'h5a5a3c3c;
    repeat (4) @(posedge CLK);
    chk(GPIO_OE, 32'hff0000ff);
    chk(GPIO_O & GPIO_OE, 32'h120000c3);
    rd(IDX_LO_OUT, 16'ha5c3);
    rd(IDX_HI_OUT, 16'h1234);
    rd(IDX_LO_IN, 16'h3cc3);
    rd(IDX_HI_IN, 16'h125a);
    $display("Port registers done");
    USB_TXEN <= 1'b1;
    HSS_O <= 4'ha;
    HSS_OE <= 4'hf;
    SPI_O <= 4'h5;
    SPI_OE <= 4'hd;
    wr(IDX_CTRL, 16'h40a0);
    repeat (3) @(posedge CLK);
    chk({GPIO_OE[30], GPIO_O[30]}, 2'b11);
    chk({GPIO_O[26], GPIO_O[18:16]}, 4'ha);
    chk(GPIO_OE[11:8], 4'hd);
    chk(SPI_I[1], 1'b0);
    wr(IDX_CTRL, 16'h48a0);
    ext_v <= 32'h5a5abc3c;
    repeat (4) @(posedge CLK);
    chk(SPI_I[1], 1'b1);
    chk(HSS_I, 4'ha);
    HSS_O <= 4'h6;
    wr(IDX_CTRL, 16'h08f0);
    repeat (4) @(posedge CLK);
    chk({XD_O[15:12], XD_O[11:8] & 4'hd}, 8'h65);
    chk(XD_ROUTE, 8'hff);
    chk(XD_OE, 8'hfd);
    chk(HSS_I, 4'h6);
    chk({GPIO_OE[26], GPIO_OE[18:16], GPIO_OE[11:8]}, 8'h80);
    chk({GPIO_OE[30], GPIO_O[30]}, 2'b10);
    chk(SPI_I[1], 1'b0);
    $display("Routing done");
    ALT_O <= 32'h000000a5;
    ALT_OE <= 32'h000000f0;
    for (int m = 0; m < 8; m++) begin
      wr(IDX_CTRL, 16'(m << 8));
      repeat (2) @(posedge CLK);
      chk(MODE_SEL, m[2:0]);
      chk(LOWGRP_OWN, m inside {4, 5, 6});
      chk(GPIO_OE[7:0], (m inside {4, 5, 6}) ? 8'hf0 : 8'hff);
    end
    $display("Modes done");
    wr(IDX_CTRL, 16'h0000);
    wr(IDX_HI_DIR, 16'h0000);
    ext_v <= 32'h03000000;
    wr(IDX_IRQ_EN, 16'h0003);
    wr(IDX_CTRL, 16'h0005);
    ext_v <= 32'h00000000;
    repeat (6) @(posedge CLK);
    chk(IRQ, 1'b1);
    rd(IDX_IRQ_STAT, 16'h0003);
    wr(IDX_IRQ_EN, 16'h0000);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0);
    wr(IDX_IRQ_EN, 16'h0003);
    wr(IDX_CTRL, 16'h000a);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0);
    wr(IDX_IRQ_CLR, 16'h0003);
    rd(IDX_IRQ_STAT, 16'h0000);
    wr(IDX_CTRL, 16'h000f);
    ext_v <= 32'h01000000;
    repeat (6) @(posedge CLK);
    chk(IRQ, 1'b1);
    rd(IDX_IRQ_STAT, 16'h0001);
    wr(IDX_IRQ_CLR, 16'h0003);
    ext_v <= 32'h02000000;
    repeat (6) @(posedge CLK);
    rd(IDX_IRQ_STAT, 16'h0002);
    $display("Interrupts done");
    wr(IDX_CTRL, 16'h8100);
    wr(IDX_CTRL, 16'h0205);
    rd(IDX_CTRL, 16'h8105);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rd(IDX_CTRL, 16'h0000);
    wr(IDX_CTRL, 16'h0200);
    rd(IDX_CTRL, 16'h0200);
    $display("Write protect done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
